// File: logic/pss_consts.svh
// constants for position scaling and preset block
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
`define PSS_ADR_CONFIG 8'h00
`define PSS_ADR_NUMER 8'h04
`define PSS_ADR_DENOM 8'h08
`define PSS_ADR_PRESET 8'h0c
`define PSS_ADR_CONTROL 8'h10
`define PSS_ADR_STATUS 8'h14
`define PSS_ADR_POSITION 8'h18
`define PSS_ADR_VELOCITY 8'h1c
`define PSS_ADR_OFFSET 8'h20
`define PSS_CFG_RSVD_HI 7
`define PSS_CFG_NEG_BIT 8
`define PSS_CFG_VEL_BIT 9
`define PSS_CFG_INV_BIT 16
`define PSS_CTL_APPLY_BIT 0
`define PSS_CTL_COMMIT_BIT 1
`define PSS_RATIO_MIN 32'h0000_0001
`define PSS_RATIO_MAX 32'h0000_7fff
`define PSS_RST_CONFIG 32'h0000_0000
`define PSS_RST_RATIO 15'h0001
`define PSS_RST_PRESET 32'h0000_0000
`define PSS_ERR_NONE 4'h0
`define PSS_ERR_CFG 4'h1
`define PSS_ERR_NUMER 4'h6
`define PSS_ERR_DENOM 4'h7
`define PSS_ERR_RATIO 4'h8
`define PSS_CLK_NS 100
`define PSS_MS_NS 1000000
`define PSS_VEL_SLOW_MS 16'd160
`define PSS_VEL_FAST_MS 16'd60
`define PSS_MS_PER_S 16'd1000
`endif

// File: logic/pss_pkg.sv
// types shared by the position scaling and preset block
`default_nettype none
package pss_pkg;
	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] numer;
		logic [31:0] denom;
		logic [31:0] target;
	} pss_setup_t;
	typedef struct packed {
		logic invert;
		logic negate;
		logic fast_vel;
		logic [14:0] numer;
		logic [14:0] denom;
		logic [31:0] target;
	} pss_active_t;
	typedef enum logic [1:0] {
		PSS_IDLE = 2'b00,
		PSS_RUN = 2'b01,
		PSS_DONE = 2'b10
	} pss_div_state_t;
endpackage
`default_nettype wire

// File: logic/pss_divider.sv
// iterative unsigned restoring divider, one quotient bit per cycle
`timescale 1ns/100ps
`default_nettype none
module pss_divider #(
	parameter int DW = 48,
	parameter int VW = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [DW-1:0] dividend_i,
	input wire logic [VW-1:0] divisor_i,
	output logic busy_o,
	output logic done_o,
	output logic [DW-1:0] quot_o
);
	localparam int CW = $clog2(DW + 1);
	pss_pkg::pss_div_state_t state_reg;
	logic [VW-1:0] rem_reg;
	logic [VW-1:0] div_reg;
	logic [CW-1:0] cnt_reg;
	logic [VW:0] trial;
	assign trial = {rem_reg, quot_o[DW-1]};
	assign busy_o = (state_reg != pss_pkg::PSS_IDLE);
	assign done_o = (state_reg == pss_pkg::PSS_DONE);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= pss_pkg::PSS_IDLE;
			rem_reg <= '0;
			div_reg <= '0;
			cnt_reg <= '0;
			quot_o <= '0;
		end else begin
			unique case (state_reg)
				pss_pkg::PSS_IDLE: begin
					if (start_i) begin
						quot_o <= dividend_i;
						div_reg <= divisor_i;
						rem_reg <= '0;
						cnt_reg <= CW'(DW);
						state_reg <= pss_pkg::PSS_RUN;
					end
				end
				pss_pkg::PSS_RUN: begin
					if (trial >= {1'b0, div_reg}) begin
						rem_reg <= VW'(trial - {1'b0, div_reg});
						quot_o <= {quot_o[DW-2:0], 1'b1};
					end else begin
						rem_reg <= trial[VW-1:0];
						quot_o <= {quot_o[DW-2:0], 1'b0};
					end
					cnt_reg <= cnt_reg - CW'(1);
					if (cnt_reg == CW'(1))
						state_reg <= pss_pkg::PSS_DONE;
				end
				pss_pkg::PSS_DONE: begin
					state_reg <= pss_pkg::PSS_IDLE;
				end
				default: begin
					state_reg <= pss_pkg::PSS_IDLE;
				end
			endcase
		end
	end
	sequence s_div_run;
		busy_o [*8];
	endsequence
	property p_div_bound;
		@(posedge clk_i) disable iff (rst_i)
		(start_i && !busy_o) |=> s_div_run ##[1:80] done_o;
	endproperty
	a_div_finish: assert property (p_div_bound) else $error("divider did not finish");
endmodule
`default_nettype wire

// File: logic/pss_velocity.sv
// rate of change in counts per second over a selectable window
`timescale 1ns/100ps
`default_nettype none
`include "pss_consts.svh"
module pss_velocity #(
	parameter int MS_CYCLES = 10000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] pos_i,
	input wire logic fast_i,
	output logic [31:0] vel_o,
	output logic vel_valid_o
);
	logic [15:0] tick_reg;
	logic ms_tick;
	logic [15:0] ms_cnt_reg;
	logic [15:0] win_ms;
	logic fast_reg;
	logic [31:0] prev_reg;
	logic [31:0] delta;
	logic [31:0] mag;
	logic sign_reg;
	logic start;
	logic done;
	logic [47:0] quot;
	assign ms_tick = (tick_reg == 16'(MS_CYCLES - 1));
	assign win_ms = fast_reg ? `PSS_VEL_FAST_MS : `PSS_VEL_SLOW_MS;
	assign start = ms_tick && (ms_cnt_reg >= win_ms - 16'h0001);
	assign delta = pos_i - prev_reg;
	assign mag = delta[31] ? (32'h0 - delta) : delta;
	always_ff @(posedge clk_i) begin
		if (rst_i || ms_tick)
			tick_reg <= '0;
		else
			tick_reg <= tick_reg + 16'h0001;
	end
	// the window length changes only at a window boundary, so no window is cut short
	always_ff @(posedge clk_i) begin
		if (rst_i)
			fast_reg <= 1'b0;
		else if (start)
			fast_reg <= fast_i;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || start)
			ms_cnt_reg <= '0;
		else if (ms_tick)
			ms_cnt_reg <= ms_cnt_reg + 16'h0001;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_reg <= '0;
			sign_reg <= 1'b0;
		end else if (start) begin
			prev_reg <= pos_i;
			sign_reg <= delta[31];
		end
	end
	// counts per window scaled to counts per second
	pss_divider #(.DW(48), .VW(16)) u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(start),
		.dividend_i(48'(mag) * 48'(`PSS_MS_PER_S)),
		.divisor_i(win_ms),
		.busy_o(),
		.done_o(done),
		.quot_o(quot)
	);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vel_o <= '0;
			vel_valid_o <= 1'b0;
		end else begin
			vel_valid_o <= done;
			if (done)
				vel_o <= sign_reg ? (32'h0 - quot[31:0]) : quot[31:0];
		end
	end
	a_vel_window: assert property (@(posedge clk_i) disable iff (rst_i)
		start |-> ms_tick && (ms_cnt_reg == win_ms - 16'h0001)) else $error("velocity window length wrong");
endmodule
`default_nettype wire

// File: logic/pss_top.sv
// position scaling, direction, preset offset and velocity with wishbone registers
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "pss_consts.svh"
module pss_top #(
	parameter int MS_CYCLES = (`PSS_MS_NS + `PSS_CLK_NS - 1) / `PSS_CLK_NS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [31:0] raw_data_i,
	input wire logic raw_valid_i,
	input wire logic nv_restore_i,
	input wire logic [31:0] nv_data_i,
	output logic nv_wr_o,
	output logic [31:0] nv_data_o,
	output logic [31:0] pos_o,
	output logic pos_valid_o,
	output logic [31:0] vel_o,
	output logic vel_valid_o
);
	pss_pkg::pss_setup_t stage_reg;
	pss_pkg::pss_active_t act_reg;
	logic [3:0] err_reg;
	logic apply_reg;
	logic apply_prev_reg;
	logic [31:0] offset_reg;
	logic [31:0] dir_scaled_reg;
	logic wr_stb;
	logic commit;
	logic commit_ok;
	logic [3:0] check_code;
	logic preset_edge;
	logic div_start;
	logic div_busy;
	logic div_done;
	logic [47:0] quot;
	logic [31:0] raw_eff;
	logic [31:0] scaled;
	logic [31:0] dir_val;

	// byte lane merge for writes
	function automatic logic [31:0] pss_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction

	// validation of a staged setup block, first failing check wins
	function automatic logic [3:0] pss_check(input pss_pkg::pss_setup_t s);
		logic [3:0] c;
		c = `PSS_ERR_NONE;
		if (s.cfg[`PSS_CFG_RSVD_HI:0] != '0)
			c = `PSS_ERR_CFG;
		else if (s.numer < `PSS_RATIO_MIN || s.numer > `PSS_RATIO_MAX)
			c = `PSS_ERR_NUMER;
		else if (s.denom < `PSS_RATIO_MIN || s.denom > `PSS_RATIO_MAX)
			c = `PSS_ERR_DENOM;
		else if (s.numer > s.denom)
			c = `PSS_ERR_RATIO;
		return c;
	endfunction

	function automatic logic pss_hit(input logic [7:0] adr, input logic [7:0] reg_adr);
		return adr == reg_adr;
	endfunction

	// direction reversal, shared by the datapath and its checks
	function automatic logic [31:0] pss_dir(input logic neg, input logic [31:0] v);
		return neg ? (32'h0 - v) : v;
	endfunction

	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign commit = wr_stb && pss_hit(wb_adr_i, `PSS_ADR_CONTROL) && wb_sel_i[0]
		&& wb_dat_i[`PSS_CTL_COMMIT_BIT];
	assign check_code = pss_check(stage_reg);
	assign commit_ok = commit && (check_code == `PSS_ERR_NONE);
	assign preset_edge = apply_reg && !apply_prev_reg;

	// wishbone classic slave: ack one cycle after the request is seen
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
			unique case (wb_adr_i)
				`PSS_ADR_CONFIG: wb_dat_o <= stage_reg.cfg;
				`PSS_ADR_NUMER: wb_dat_o <= stage_reg.numer;
				`PSS_ADR_DENOM: wb_dat_o <= stage_reg.denom;
				`PSS_ADR_PRESET: wb_dat_o <= stage_reg.target;
				`PSS_ADR_CONTROL: wb_dat_o <= {31'h0, apply_reg};
				`PSS_ADR_STATUS: wb_dat_o <= {27'h0, div_busy, err_reg};
				`PSS_ADR_POSITION: wb_dat_o <= pos_o;
				`PSS_ADR_VELOCITY: wb_dat_o <= vel_o;
				`PSS_ADR_OFFSET: wb_dat_o <= offset_reg;
				default: wb_dat_o <= '0;
			endcase
		end
	end

	// staged setup block; writing the target here never touches the offset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stage_reg.cfg <= `PSS_RST_CONFIG;
			stage_reg.numer <= 32'(`PSS_RST_RATIO);
			stage_reg.denom <= 32'(`PSS_RST_RATIO);
			stage_reg.target <= `PSS_RST_PRESET;
		end else if (wr_stb) begin
			if (pss_hit(wb_adr_i, `PSS_ADR_CONFIG))
				stage_reg.cfg <= pss_merge(stage_reg.cfg, wb_dat_i, wb_sel_i);
			if (pss_hit(wb_adr_i, `PSS_ADR_NUMER))
				stage_reg.numer <= pss_merge(stage_reg.numer, wb_dat_i, wb_sel_i);
			if (pss_hit(wb_adr_i, `PSS_ADR_DENOM))
				stage_reg.denom <= pss_merge(stage_reg.denom, wb_dat_i, wb_sel_i);
			if (pss_hit(wb_adr_i, `PSS_ADR_PRESET))
				stage_reg.target <= pss_merge(stage_reg.target, wb_dat_i, wb_sel_i);
		end
	end

	// a rejected block leaves the active setup untouched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_reg.invert <= 1'b0;
			act_reg.negate <= 1'b0;
			act_reg.fast_vel <= 1'b0;
			act_reg.numer <= `PSS_RST_RATIO;
			act_reg.denom <= `PSS_RST_RATIO;
			act_reg.target <= `PSS_RST_PRESET;
		end else if (commit_ok) begin
			act_reg.invert <= stage_reg.cfg[`PSS_CFG_INV_BIT];
			act_reg.negate <= stage_reg.cfg[`PSS_CFG_NEG_BIT];
			act_reg.fast_vel <= stage_reg.cfg[`PSS_CFG_VEL_BIT];
			act_reg.numer <= stage_reg.numer[14:0];
			act_reg.denom <= stage_reg.denom[14:0];
			act_reg.target <= stage_reg.target;
		end
	end

	// error code only clears when a valid block arrives
	always_ff @(posedge clk_i) begin
		if (rst_i)
			err_reg <= `PSS_ERR_NONE;
		else if (commit)
			err_reg <= check_code;
	end

	// apply is a level; only its 0-to-1 step loads an offset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			apply_reg <= 1'b0;
			apply_prev_reg <= 1'b0;
		end else begin
			apply_prev_reg <= apply_reg;
			if (wr_stb && pss_hit(wb_adr_i, `PSS_ADR_CONTROL) && wb_sel_i[0])
				apply_reg <= wb_dat_i[`PSS_CTL_APPLY_BIT];
		end
	end

	// commit wins over a same-cycle preset, so a new block always starts clean
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			offset_reg <= '0;
			nv_wr_o <= 1'b0;
			nv_data_o <= '0;
		end else begin
			nv_wr_o <= 1'b0;
			if (commit_ok) begin
				offset_reg <= '0;
				nv_wr_o <= 1'b1;
				nv_data_o <= '0;
			end else if (preset_edge) begin
				offset_reg <= act_reg.target - dir_scaled_reg;
				nv_wr_o <= 1'b1;
				nv_data_o <= act_reg.target - dir_scaled_reg;
			end else if (nv_restore_i) begin
				offset_reg <= nv_data_i;
			end
		end
	end

	// samples arriving while a division runs are dropped; the next one is used
	assign raw_eff = act_reg.invert ? ~raw_data_i : raw_data_i;
	assign div_start = raw_valid_i && !div_busy;
	assign scaled = quot[31:0];
	assign dir_val = pss_dir(act_reg.negate, scaled);

	pss_divider #(.DW(48), .VW(16)) u_scale (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(div_start),
		.dividend_i(48'(raw_eff) * 48'(act_reg.numer)),
		.divisor_i({1'b0, act_reg.denom}),
		.busy_o(div_busy),
		.done_o(div_done),
		.quot_o(quot)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_scaled_reg <= '0;
			pos_o <= '0;
			pos_valid_o <= 1'b0;
		end else begin
			pos_valid_o <= div_done;
			if (div_done) begin
				dir_scaled_reg <= dir_val;
				pos_o <= dir_val + offset_reg;
			end
		end
	end

	pss_velocity #(.MS_CYCLES(MS_CYCLES)) u_vel (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pos_i(pos_o),
		.fast_i(act_reg.fast_vel),
		.vel_o(vel_o),
		.vel_valid_o(vel_valid_o)
	);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_strobe;
		preset_edge && !commit_ok;
	endsequence
	sequence s_offset_loaded;
		offset_reg == $past(act_reg.target) - $past(dir_scaled_reg);
	endsequence
	sequence s_raw_taken;
		raw_valid_i && !div_busy;
	endsequence
	// one load edge, one edge per dividend bit, then the registered output
	sequence s_pos_out;
		##49 div_done ##1 pos_valid_o;
	endsequence
	sequence s_bad_commit;
		commit && check_code != `PSS_ERR_NONE && !preset_edge && !nv_restore_i;
	endsequence
	sequence s_kept;
		$stable(act_reg) && $stable(offset_reg) && !nv_wr_o;
	endsequence

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	a_preset_load: assert property (s_strobe |=> s_offset_loaded) else $error("offset not target minus value");
	a_preset_store: assert property (s_strobe |=> nv_wr_o && nv_data_o == offset_reg) else $error("nv store missed");
	a_commit_clear: assert property (commit_ok |=> offset_reg == 32'h0 && nv_wr_o) else $error("offset not cleared");
	a_target_only: assert property (wr_stb && pss_hit(wb_adr_i, `PSS_ADR_PRESET) && !preset_edge && !nv_restore_i
		|=> $stable(offset_reg)) else $error("target write moved offset");
	a_ratio_reject: assert property (commit && stage_reg.numer > stage_reg.denom
		&& stage_reg.denom >= `PSS_RATIO_MIN && stage_reg.denom <= `PSS_RATIO_MAX
		&& stage_reg.cfg[`PSS_CFG_RSVD_HI:0] == '0
		&& stage_reg.numer <= `PSS_RATIO_MAX |=> err_reg == `PSS_ERR_RATIO && $stable(act_reg))
		else $error("bad ratio accepted");
	a_pos_compose: assert property (div_done |=> pos_valid_o
		&& pos_o == pss_dir($past(act_reg.negate), $past(scaled)) + $past(offset_reg))
		else $error("position composition wrong");
	a_scale_bound: assert property (div_start |-> ##49 (div_done && quot <= 48'($past(raw_eff, 49))))
		else $error("scaled above raw");
	a_cfg_decode: assert property (commit_ok |=> act_reg.negate == $past(stage_reg.cfg[`PSS_CFG_NEG_BIT])
		&& act_reg.fast_vel == $past(stage_reg.cfg[`PSS_CFG_VEL_BIT])) else $error("config bits misdecoded");
	a_invert_decode: assert property (commit_ok |=> act_reg.invert == $past(stage_reg.cfg[`PSS_CFG_INV_BIT]))
		else $error("invert bit misdecoded");
	a_ratio_active: assert property (act_reg.numer != 15'h0 && act_reg.numer <= act_reg.denom)
		else $error("active ratio out of range");
	a_reject_keep: assert property (s_bad_commit |=> s_kept) else $error("rejected block changed state");
	a_err_clear: assert property (commit_ok |=> err_reg == `PSS_ERR_NONE) else $error("error code not cleared");
	a_target_act: assert property (wr_stb && pss_hit(wb_adr_i, `PSS_ADR_PRESET) |=> $stable(act_reg.target))
		else $error("target write reached active setup");
	a_apply_write: assert property (wr_stb && pss_hit(wb_adr_i, `PSS_ADR_CONTROL) && wb_sel_i[0]
		|=> apply_reg == $past(wb_dat_i[`PSS_CTL_APPLY_BIT])) else $error("apply level not captured");
	a_edge_once: assert property (preset_edge |=> !preset_edge) else $error("apply edge seen twice");

	// the store has limited endurance: only a commit or a fresh apply edge may write it
	a_store_cause: assert property (nv_wr_o |-> $past(commit_ok || preset_edge)) else $error("stray store write");
	a_commit_store: assert property (commit_ok |=> nv_wr_o && nv_data_o == 32'h0)
		else $error("cleared offset not stored");
	a_nv_hold: assert property (!nv_wr_o |-> $stable(nv_data_o)) else $error("store data moved without write");
	a_offset_restore: assert property (nv_restore_i && !commit_ok && !preset_edge
		|=> offset_reg == $past(nv_data_i)) else $error("offset not restored");

	a_pos_timing: assert property (s_raw_taken |-> s_pos_out) else $error("position latency wrong");
	a_pos_plain: assert property (div_done && !act_reg.negate |=> dir_scaled_reg == $past(scaled))
		else $error("positive direction altered value");
	a_pos_pulse: assert property (pos_valid_o |=> !pos_valid_o) else $error("position valid held");
	a_vel_pulse: assert property (vel_valid_o |=> !vel_valid_o) else $error("velocity valid held");
	a_ack_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	a_dat_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o))
		else $error("read data moved without read");
endmodule
`default_nettype wire

// File: test/pss_far_model.sv
// far-side model: raw position source and nonvolatile offset store
`timescale 1ns/100ps
`default_nettype none
module pss_far_model (
	input wire logic clk_i,
	input wire logic send_i,
	input wire logic [31:0] value_i,
	input wire logic restore_i,
	input wire logic nv_wr_i,
	input wire logic [31:0] nv_data_i,
	output logic [31:0] raw_data_o,
	output logic raw_valid_o,
	output logic nv_restore_o,
	output logic [31:0] nv_data_o,
	output logic [31:0] nv_writes_o
);
	initial begin
		raw_data_o = 32'h0000_0000;
		raw_valid_o = 1'b0;
		nv_restore_o = 1'b0;
		nv_data_o = 32'h0000_0000;
		nv_writes_o = 32'h0000_0000;
	end
	// outside a sample the data bus toggles so a stale value is never mistaken for a fresh one
	always @(posedge clk_i) begin
		raw_valid_o <= send_i;
		raw_data_o <= send_i ? value_i : ~raw_data_o;
		nv_restore_o <= restore_i;
	end
	// no reset here: contents outlive a reset of the block, as flash outlives power loss
	always @(posedge clk_i) begin
		if (nv_wr_i === 1'b1) begin
			nv_data_o <= nv_data_i;
			nv_writes_o <= nv_writes_o + 32'h1;
		end
	end
endmodule
`default_nettype wire

// File: test/pss_top_tb_top.sv
// self-checking bench for the position scaling and preset block
`timescale 1ns/100ps
`default_nettype none
`include "pss_consts.svh"
`define CHECK_EQ(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin mismatches++; \
	$display("BAD %s expected %h seen %h", nm, ex, got); end end
module pss_top_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_o, raw_data, nv_store, nv_data_o, pos_o, vel_o, nv_writes, value;
	logic wb_ack_o, raw_valid, nv_restore, nv_wr_o, pos_valid_o, vel_valid_o;
	logic send = 1'b0;
	logic restore = 1'b0;
	int mismatches = 0;
	int n_tests = 0;
	int cnt = 0;
	int gap = 0;
	always #50 clk_i = ~clk_i;
	pss_top #(.MS_CYCLES(10)) u_pss_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .raw_data_i(raw_data), .raw_valid_i(raw_valid), .nv_restore_i(nv_restore),
		.nv_data_i(nv_store), .nv_wr_o(nv_wr_o), .nv_data_o(nv_data_o), .pos_o(pos_o), .pos_valid_o(pos_valid_o),
		.vel_o(vel_o), .vel_valid_o(vel_valid_o));
	pss_far_model u_pss_far_model (.clk_i(clk_i), .send_i(send), .value_i(value), .restore_i(restore),
		.nv_wr_i(nv_wr_o), .nv_data_i(nv_data_o), .raw_data_o(raw_data), .raw_valid_o(raw_valid),
		.nv_restore_o(nv_restore), .nv_data_o(nv_store), .nv_writes_o(nv_writes));
	// spacing between velocity pulses, in clock cycles
	always @(posedge clk_i) begin
		if (vel_valid_o === 1'b1) begin
			gap <= cnt;
			cnt <= 1;
		end else begin
			cnt <= cnt + 1;
		end
	end
	task automatic tally_and_finish();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		if (wb_ack_o !== 1'b1)
			mismatches++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		wb(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0, q);
	endtask
	task automatic commit(input logic [31:0] c, input logic [31:0] n, input logic [31:0] d, input logic [31:0] t);
		wr(`PSS_ADR_CONFIG, c);
		wr(`PSS_ADR_NUMER, n);
		wr(`PSS_ADR_DENOM, d);
		wr(`PSS_ADR_PRESET, t);
		wr(`PSS_ADR_CONTROL, 32'h0000_0002);
		repeat (4) @(posedge clk_i);
	endtask
	task automatic sample(input logic [31:0] v, output logic [31:0] p, output int lat);
		lat = 0;
		@(posedge clk_i);
		send <= 1'b1;
		value <= v;
		@(posedge clk_i);
		send <= 1'b0;
		do begin
			@(negedge clk_i);
			lat++;
		end while (pos_valid_o !== 1'b1 && lat < 200);
		if (pos_valid_o !== 1'b1)
			mismatches++;
		p = pos_o;
	endtask
	task automatic wait_vel();
		int n;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (vel_valid_o !== 1'b1 && n < 3000);
		if (vel_valid_o !== 1'b1)
			mismatches++;
		@(negedge clk_i);
	endtask
	task automatic t_reset();
		logic [31:0] q;
		rd(`PSS_ADR_NUMER, q);
		`CHECK_EQ("numer reset", 32'h1, q)
		rd(`PSS_ADR_DENOM, q);
		`CHECK_EQ("denom reset", 32'h1, q)
		rd(`PSS_ADR_CONFIG, q);
		`CHECK_EQ("config reset", 32'h0, q)
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40, q);
		`CHECK_EQ("unmapped", 32'h0, q)
	endtask
	task automatic t_errors();
		logic [31:0] tc [5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
		logic [31:0] tn [5] = '{32'h1, 32'h0, 32'h1, 32'hc8, 32'h7fff};
		logic [31:0] td [5] = '{32'h1, 32'h1, 32'h8000, 32'h64, 32'h7fff};
		logic [3:0] te [5] = '{4'h1, 4'h6, 4'h7, 4'h8, 4'h0};
		logic [31:0] q;
		for (int i = 0; i < 5; i++) begin
			commit(tc[i], tn[i], td[i], 32'h0);
			rd(`PSS_ADR_STATUS, q);
			`CHECK_EQ("error code", te[i], q[3:0])
		end
	endtask
	task automatic t_preset();
		logic [31:0] p;
		logic [31:0] w;
		int l;
		commit(32'h0, 32'h32, 32'h7f, 32'h1388);
		sample(32'h3e8, p, l);
		`CHECK_EQ("scaled", 32'h3e8 * 32'h32 / 32'h7f, p)
		wr(`PSS_ADR_PRESET, 32'h2710);
		wr(`PSS_ADR_CONTROL, 32'h0);
		sample(32'h3e8, p, l);
		`CHECK_EQ("target held", 32'h189, p)
		w = nv_writes;
		wr(`PSS_ADR_CONTROL, 32'h1);
		repeat (4) @(posedge clk_i);
		`CHECK_EQ("stored offset", 32'h1388 - 32'h189, nv_store)
		`CHECK_EQ("one store per preset", w + 32'h1, nv_writes)
		rd(`PSS_ADR_OFFSET, p);
		`CHECK_EQ("offset", 32'h1388 - 32'h189, p)
		sample(32'h7d0, p, l);
		`CHECK_EQ("preset pos", 32'h7d0 * 32'h32 / 32'h7f + 32'h11ff, p)
		wr(`PSS_ADR_CONTROL, 32'h0);
	endtask
	task automatic t_restore();
		logic [31:0] q;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`PSS_ADR_OFFSET, q);
		`CHECK_EQ("offset after reset", 32'h0, q)
		@(posedge clk_i);
		restore <= 1'b1;
		@(posedge clk_i);
		restore <= 1'b0;
		repeat (3) @(posedge clk_i);
		rd(`PSS_ADR_OFFSET, q);
		`CHECK_EQ("restored offset", 32'h11ff, q)
	endtask
	task automatic t_neg();
		logic [31:0] p;
		int l;
		commit(32'h100, 32'h32, 32'h7f, 32'h0);
		`CHECK_EQ("offset cleared", 32'h0, nv_store)
		sample(32'h3e8, p, l);
		`CHECK_EQ("negated", 32'h0 - 32'h189, p)
		commit(32'h1_0000, 32'h32, 32'h7f, 32'h0);
		sample(~32'h3e8, p, l);
		`CHECK_EQ("inverted raw", 32'h189, p)
	endtask
	task automatic t_vel();
		logic [31:0] p;
		int l1, l2;
		commit(32'h0, 32'h1, 32'h1, 32'h0);
		sample(32'h64, p, l1);
		repeat (3) wait_vel();
		`CHECK_EQ("slow window", 1600, gap)
		commit(32'h200, 32'h1, 32'h1, 32'h0);
		repeat (2) wait_vel();
		sample(32'h2bc, p, l2);
		`CHECK_EQ("pos latency", l1, l2)
		wait_vel();
		`CHECK_EQ("fast window", 600, gap)
		`CHECK_EQ("velocity", 32'h258 * 32'h3e8 / 32'h3c, vel_o)
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_errors();
		t_preset();
		t_restore();
		t_neg();
		t_vel();
		tally_and_finish();
	end
	// run needs roughly 8000 cycles; allow generous margin
	initial begin
		repeat (40000) @(posedge clk_i);
		mismatches++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
